/* hdl/arc_regs.svh */
// Register map, field layout, reset values and timing counts of the ramp block
`ifndef ARC_REGS_SVH
`define ARC_REGS_SVH
`define ARC_CLK_MHZ 100
`define ARC_TICK_MS 100
`define ARC_TICK_CYC (`ARC_TICK_MS * 1000 * `ARC_CLK_MHZ)
`define ARC_OFF_CTRL 32'h0000_0000
`define ARC_OFF_FIRST 32'h0000_0004
`define ARC_OFF_SECOND 32'h0000_0008
`define ARC_OFF_CEIL 32'h0000_000C
`define ARC_OFF_SSOFF 32'h0000_0010
`define ARC_OFF_RATE 32'h0000_0014
`define ARC_OFF_GAIN 32'h0000_0018
`define ARC_OFF_SHIFT 32'h0000_001C
`define ARC_OFF_STAT 32'h0000_0020
`define ARC_OFF_LEVEL 32'h0000_0024
`define ARC_OFF_OUT 32'h0000_0028
`define ARC_CTRL_EXT_BIT 0
`define ARC_RST_FIRST 32'h0000_0000
`define ARC_RST_SECOND 32'h0000_0000
`define ARC_RST_CEIL 32'h0000_4E20
`define ARC_RST_SSOFF 32'h0000_0000
`define ARC_RST_RATE 32'h0000_000A
`define ARC_RST_GAIN 32'h0000_0064
`define ARC_RST_SHIFT 32'h0000_0000
`define ARC_OUT_MAX 32'h0000_7FFF
`endif

/* hdl/arc_pkg.sv */
// Types of the analog ramp block
package arc_pkg;
  typedef enum logic [4:0] {
    ARC_IDLE = 5'b00001,
    ARC_DWELL_UP = 5'b00010,
    ARC_RUN = 5'b00100,
    ARC_DECEL = 5'b01000,
    ARC_DWELL_DN = 5'b10000
  } arc_state_t;
endpackage

/* hdl/arc_ramp.sv */
// Analog ramp control block with AXI4-Lite parameter registers
`timescale 1ns/10ps
`include "arc_regs.svh"
module arc_ramp #(
  parameter int TICK_CYC = `ARC_TICK_CYC
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Sync reset, high
  input wire logic enable_in, // Enable input
  input wire logic select_in, // Target level select
  input wire logic decel_halt_in, // Decelerated stop
  input wire logic signed [15:0] ext_first_in, // First level from other block
  input wire logic signed [15:0] ext_second_in, // Second level from other block
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready_out, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready_out, // Write data ready
  output logic [1:0] s_axi_bresp_out, // Write response
  output logic s_axi_bvalid_out, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready_out, // Read address ready
  output logic [31:0] s_axi_rdata_out, // Read data
  output logic [1:0] s_axi_rresp_out, // Read response
  output logic s_axi_rvalid_out, // Read valid
  input wire logic s_axi_rready, // Read ready
  output logic [15:0] ramp_output_out, // Scaled result 0..32767
  output logic tick_out // 100 ms tick pulse
);
  if (TICK_CYC < 2) begin : g_tick_chk
    $error("TICK_CYC too small");
  end

  // ****************************************
  // Parameter registers
  // ****************************************
  logic [31:0] ctrl, first_level, second_level, level_ceiling, start_stop_offset;
  logic [31:0] rate, gain, zero_shift;
  logic aw_hold, w_hold, next_aw_hold, next_w_hold, next_bvalid;
  logic [31:0] aw_addr, w_data;
  logic [3:0] w_strb;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  // Next hold state, so the readies can come straight from flops
  always_comb begin
    next_aw_hold = aw_hold || (s_axi_awvalid && s_axi_awready_out);
    next_w_hold = w_hold || (s_axi_wvalid && s_axi_wready_out);
    next_bvalid = s_axi_bvalid_out && !s_axi_bready;
    if (aw_hold && w_hold && !s_axi_bvalid_out) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
    end
  end

  // Address and data taken in either order, response once both held
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'b00;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      s_axi_bvalid_out <= next_bvalid;
      s_axi_awready_out <= !next_aw_hold && !next_bvalid;
      s_axi_wready_out <= !next_w_hold && !next_bvalid;
      if (s_axi_awvalid && s_axi_awready_out) aw_addr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready_out) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_hold && w_hold && !s_axi_bvalid_out) begin
        s_axi_bresp_out <= (aw_addr[31:2] <= (`ARC_OFF_SHIFT >> 2)) ? 2'b00 : 2'b10;
      end
    end
  end

  // Register stores; ranges are the writer's duty
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl <= 32'h0000_0000;
      first_level <= `ARC_RST_FIRST;
      second_level <= `ARC_RST_SECOND;
      level_ceiling <= `ARC_RST_CEIL;
      start_stop_offset <= `ARC_RST_SSOFF;
      rate <= `ARC_RST_RATE;
      gain <= `ARC_RST_GAIN;
      zero_shift <= `ARC_RST_SHIFT;
    end else if (aw_hold && w_hold && !s_axi_bvalid_out) begin
      case ({aw_addr[31:2], 2'b00})
        `ARC_OFF_CTRL: ctrl <= merge(ctrl, w_data, w_strb);
        `ARC_OFF_FIRST: first_level <= merge(first_level, w_data, w_strb);
        `ARC_OFF_SECOND: second_level <= merge(second_level, w_data, w_strb);
        `ARC_OFF_CEIL: level_ceiling <= merge(level_ceiling, w_data, w_strb);
        `ARC_OFF_SSOFF: start_stop_offset <= merge(start_stop_offset, w_data, w_strb);
        `ARC_OFF_RATE: rate <= merge(rate, w_data, w_strb);
        `ARC_OFF_GAIN: gain <= merge(gain, w_data, w_strb);
        `ARC_OFF_SHIFT: zero_shift <= merge(zero_shift, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // ****************************************
  // Tick and ramp engine
  // ****************************************
  logic [31:0] tick_cnt;
  logic tick;
  arc_pkg::arc_state_t state;
  logic signed [31:0] level, target, next_level;
  logic prev_en, prev_sel, prev_halt, locked;
  logic signed [31:0] ss_level, sel_level, step, ceil_s, goal;

  // Free-running 100 ms divider
  // tick only updates
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == 32'(TICK_CYC - 1));
      tick_cnt <= (tick_cnt == 32'(TICK_CYC - 1)) ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    end
  end
  assign tick_out = tick;

  assign ss_level = $signed(zero_shift) + $signed(start_stop_offset);
  assign sel_level = ctrl[`ARC_CTRL_EXT_BIT] ?
    (select_in ? 32'(ext_second_in) : 32'(ext_first_in)) :
    (select_in ? $signed(second_level) : $signed(first_level));
  // tenth of rate per tick, never zero
  assign step = ($signed(rate) < 32'sd10) ? 32'sd1 : $signed(rate) / 32'sd10;
  assign ceil_s = $signed(level_ceiling);

  // Step toward a goal, landing exactly on it
  function automatic logic signed [31:0] approach(input logic signed [31:0] cur,
                                                  input logic signed [31:0] goal,
                                                  input logic signed [31:0] stp);
    logic signed [31:0] r;
    r = cur;
    if (cur < goal) r = (goal - cur <= stp) ? goal : cur + stp;
    else if (cur > goal) r = (cur - goal <= stp) ? goal : cur - stp;
    return r;
  endfunction

  // Stop ramps to the latched start/stop level; otherwise follow select at once
  assign goal = (state == arc_pkg::ARC_DECEL) ? target : sel_level;
  assign next_level = (approach(level, goal, step) > ceil_s) ? ceil_s
                      : approach(level, goal, step);

  // Ramp state machine, stepped only on ticks
  // edges against last tick sample
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= arc_pkg::ARC_IDLE;
      level <= 32'sh0000_0000;
      target <= 32'sh0000_0000;
      prev_en <= 1'b0;
      prev_sel <= 1'b0;
      prev_halt <= 1'b0;
      locked <= 1'b0;
    end else if (tick) begin
      prev_en <= enable_in;
      prev_sel <= select_in;
      prev_halt <= decel_halt_in;
      // release lock only when both low
      if (locked && !enable_in && !decel_halt_in) locked <= 1'b0;
      if (prev_en && !enable_in) begin
        state <= arc_pkg::ARC_IDLE;
        level <= $signed(zero_shift);
      end else begin
        case (state)
          arc_pkg::ARC_IDLE: begin
            level <= $signed(zero_shift);
            if (!prev_en && enable_in && !locked && !decel_halt_in) begin
              level <= (ss_level > ceil_s) ? ceil_s : ss_level;
              state <= arc_pkg::ARC_DWELL_UP;
            end
          end
          arc_pkg::ARC_DWELL_UP: begin
            target <= sel_level;
            level <= next_level;
            state <= arc_pkg::ARC_RUN;
          end
          arc_pkg::ARC_RUN: begin
            if (!prev_halt && decel_halt_in) begin
              target <= ss_level;
              locked <= 1'b1;
              state <= arc_pkg::ARC_DECEL;
            end else begin
              if (prev_sel != select_in || target != sel_level) target <= sel_level;
              level <= next_level;
            end
          end
          arc_pkg::ARC_DECEL: begin
            level <= next_level;
            if (next_level == target || next_level == level) state <= arc_pkg::ARC_DWELL_DN;
          end
          arc_pkg::ARC_DWELL_DN: begin
            level <= $signed(zero_shift);
            state <= arc_pkg::ARC_IDLE;
          end
          default: state <= arc_pkg::ARC_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Scaled output
  // ****************************************
  logic signed [47:0] scaled;
  // (level - shift) * 100 / gain
  assign scaled = (48'(level - $signed(zero_shift)) * 48'sd100) / $signed({16'h0000, gain});

  always_ff @(posedge clk_in) begin
    if (rst_in) ramp_output_out <= 16'h0000;
    else if (gain == 32'h0000_0000) ramp_output_out <= 16'h7FFF;
    else if (scaled < 48'sd0) ramp_output_out <= 16'h0000;
    else if (scaled > 48'(`ARC_OUT_MAX)) ramp_output_out <= 16'h7FFF;
    else ramp_output_out <= scaled[15:0];
  end

  // Read side, one read at a time
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_arready_out <= 1'b0;
      s_axi_rresp_out <= 2'b00;
      case ({s_axi_araddr[31:2], 2'b00})
        `ARC_OFF_CTRL: s_axi_rdata_out <= ctrl;
        `ARC_OFF_FIRST: s_axi_rdata_out <= first_level;
        `ARC_OFF_SECOND: s_axi_rdata_out <= second_level;
        `ARC_OFF_CEIL: s_axi_rdata_out <= level_ceiling;
        `ARC_OFF_SSOFF: s_axi_rdata_out <= start_stop_offset;
        `ARC_OFF_RATE: s_axi_rdata_out <= rate;
        `ARC_OFF_GAIN: s_axi_rdata_out <= gain;
        `ARC_OFF_SHIFT: s_axi_rdata_out <= zero_shift;
        `ARC_OFF_STAT: s_axi_rdata_out <= {26'h000_0000, locked, state};
        `ARC_OFF_LEVEL: s_axi_rdata_out <= level;
        `ARC_OFF_OUT: s_axi_rdata_out <= {16'h0000, ramp_output_out};
        default: begin
          s_axi_rdata_out <= 32'h0000_0000;
          s_axi_rresp_out <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_level_tick;
    @(posedge clk_in) disable iff (rst_in) !tick |=> $stable(level);
  endproperty
  a_level_tick: assert property (p_level_tick) else $error("level moved off tick");
  property p_ceiling;
    @(posedge clk_in) disable iff (rst_in) state == arc_pkg::ARC_RUN |-> level <= ceil_s;
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("level above ceiling");
  property p_out_range;
    @(posedge clk_in) disable iff (rst_in) ramp_output_out <= 16'h7FFF;
  endproperty
  a_out_range: assert property (p_out_range) else $error("output above range");
  property p_en_fall;
    @(posedge clk_in) disable iff (rst_in) tick && prev_en && !enable_in |=> level == $signed(zero_shift);
  endproperty
  a_en_fall: assert property (p_en_fall) else $error("enable fall not dropped");
  // start steps, rise seen then dwell ended
  sequence s_rise_seen;
    tick && state == arc_pkg::ARC_IDLE && !prev_en && enable_in && !locked && !decel_halt_in;
  endsequence
  sequence s_dwell_end;
    tick && state == arc_pkg::ARC_DWELL_UP && enable_in;
  endsequence
  property p_start;
    @(posedge clk_in) disable iff (rst_in) s_rise_seen |=> state == arc_pkg::ARC_DWELL_UP;
  endproperty
  a_start: assert property (p_start) else $error("start dwell missed");
  property p_dwell_up;
    @(posedge clk_in) disable iff (rst_in) s_dwell_end |=> state == arc_pkg::ARC_RUN;
  endproperty
  a_dwell_up: assert property (p_dwell_up) else $error("start dwell too long");
  property p_lock;
    @(posedge clk_in) disable iff (rst_in) locked && tick && state == arc_pkg::ARC_IDLE |=> state == arc_pkg::ARC_IDLE;
  endproperty
  a_lock: assert property (p_lock) else $error("restart while locked");
  property p_dwell_dn;
    @(posedge clk_in) disable iff (rst_in) tick && state == arc_pkg::ARC_DWELL_DN && enable_in |=> level == $signed(zero_shift);
  endproperty
  a_dwell_dn: assert property (p_dwell_dn) else $error("stop dwell end wrong");
  property p_tick_pulse;
    @(posedge clk_in) disable iff (rst_in) tick |=> !tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
endmodule

/* dv/arc_pgm_model.sv */
// Model of the circuit program blocks that feed the ramp block
`timescale 1ns/10ps
module arc_pgm_model (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Sync reset, high
  input wire logic tick_in, // Update tick from the ramp block
  input wire logic req_enable_in, // Requested enable level
  input wire logic req_select_in, // Requested target select
  input wire logic req_halt_in, // Requested decelerated stop
  input wire logic signed [15:0] req_first_in, // Requested first level
  input wire logic signed [15:0] req_second_in, // Requested second level
  output logic enable_out, // Enable to ramp block
  output logic select_out, // Select to ramp block
  output logic decel_halt_out, // Stop to ramp block
  output logic signed [15:0] ext_first_out, // First level source
  output logic signed [15:0] ext_second_out // Second level source
);
  // ****************
  // Program outputs
  // ****************
  // change on tick only
  // Lines move just after a tick, so each value stands a whole period
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      enable_out <= 1'b0;
      select_out <= 1'b0;
      decel_halt_out <= 1'b0;
    end else if (tick_in) begin
      // bench drops both lines before the accepted restart, only enable before the refused one
      enable_out <= req_enable_in;
      select_out <= req_select_in;
      decel_halt_out <= req_halt_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_first_out <= 16'sh0000;
      ext_second_out <= 16'sh0000;
    end else if (tick_in) begin
      ext_first_out <= req_first_in;
      ext_second_out <= req_second_in;
    end
  end
endmodule

/* dv/analog_ramp_control_tb_top.sv */
// Self-checking bench of the analog ramp block
`timescale 1ns/10ps
`include "arc_regs.svh"
module analog_ramp_control_tb_top;
  // ****************
  // Stimulus and bus
  // ****************
  localparam int TICK = 20;
  localparam logic [31:0] RA [7] = '{`ARC_OFF_FIRST, `ARC_OFF_SECOND, `ARC_OFF_CEIL,
    `ARC_OFF_SSOFF, `ARC_OFF_RATE, `ARC_OFF_GAIN, `ARC_OFF_SHIFT};
  localparam logic [31:0] RV [7] = '{`ARC_RST_FIRST, `ARC_RST_SECOND, `ARC_RST_CEIL,
    `ARC_RST_SSOFF, `ARC_RST_RATE, `ARC_RST_GAIN, `ARC_RST_SHIFT};
  logic clk_in = 1'b0, rst_in = 1'b1;
  logic req_en = 1'b0, req_sel = 1'b0, req_halt = 1'b0;
  logic signed [15:0] req_first = 16'sh0000, req_second = 16'sh0000;
  logic enable, select, halt, awready, wready, bvalid, arready, rvalid, tick;
  logic signed [15:0] ext_first, ext_second;
  logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] ramp_out;
  int miscompares = 0, n_tests = 0;

  // Free-running 100 MHz clock
  always #5 clk_in = ~clk_in;

  arc_pgm_model u_pgm (.clk_in(clk_in), .rst_in(rst_in), .tick_in(tick), .req_enable_in(req_en),
    .req_select_in(req_sel), .req_halt_in(req_halt), .req_first_in(req_first),
    .req_second_in(req_second), .enable_out(enable), .select_out(select),
    .decel_halt_out(halt), .ext_first_out(ext_first), .ext_second_out(ext_second));

  // Short tick keeps the run small; every count below follows from it
  arc_ramp #(.TICK_CYC(TICK)) u_dut (.clk_in(clk_in), .rst_in(rst_in), .enable_in(enable),
    .select_in(select), .decel_halt_in(halt), .ext_first_in(ext_first),
    .ext_second_in(ext_second), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready(rready),
    .ramp_output_out(ramp_out), .tick_out(tick));

  // Verdict and end of run
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  // A wait that runs dry ends the run at once
  task automatic hang(input string name);
    $display("[FAIL] %s expected answer seen none", name);
    miscompares++;
    final_report();
  endtask

  // Write: address and data offered together, bready held until bvalid
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) hang("write response");
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) hang("read response");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("write response", 32'h0000_0000, {30'h0000_0000, r});
  endtask

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(name, exp, d);
    chk("read response", 32'h0000_0000, {30'h0000_0000, r});
  endtask

  task automatic wait_tick();
    int n;
    for (n = 0; n < 4 * TICK; n++) begin
      @(posedge clk_in);
      if (tick) break;
    end
    if (n == 4 * TICK) hang("tick pulse");
  endtask

  // Settle a few cycles after the last tick before looking
  task automatic ticks(input int k);
    repeat (k) wait_tick();
    repeat (3) @(posedge clk_in);
  endtask

  // Program lines reach the block one tick later, seen the tick after
  task automatic drive(input logic e, input logic s, input logic h);
    @(posedge clk_in);
    req_en <= e;
    req_sel <= s;
    req_halt <= h;
    ticks(2);
  endtask

  task automatic out_chk(input logic [31:0] exp);
    chk("result port", exp, {16'h0000, ramp_out});
    rd_chk("result register", `ARC_OFF_OUT, exp);
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 7; i++) rd_chk("reset value", RA[i], RV[i]);
    axi_rd(32'h0000_0040, d, r);
    chk("unmapped read", 32'h0000_0002, {d[29:0], r});
    axi_wr(32'h0000_0040, 32'h0000_0001, r);
    chk("unmapped write", 32'h0000_0002, {30'h0000_0000, r});
    wait_tick();
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (!tick && n < 100);
    chk("tick period", 32'(TICK), 32'(n));
    wr(`ARC_OFF_SHIFT, 32'h0000_0005);
    wr(`ARC_OFF_SSOFF, 32'h0000_000A);
    wr(`ARC_OFF_RATE, 32'h0000_0064);
    wr(`ARC_OFF_FIRST, 32'h0000_0032);
    wr(`ARC_OFF_SECOND, 32'h0000_0014);
    drive(1'b1, 1'b0, 1'b0);
    rd_chk("dwell level", `ARC_OFF_LEVEL, 32'h0000_000F);
    ticks(1);
    rd_chk("first step", `ARC_OFF_LEVEL, 32'h0000_0019);
    ticks(7);
    rd_chk("first target", `ARC_OFF_LEVEL, 32'h0000_0032);
    out_chk(32'h0000_002D);
    drive(1'b1, 1'b1, 1'b0);
    ticks(6);
    rd_chk("second target", `ARC_OFF_LEVEL, 32'h0000_0014);
    out_chk(32'h0000_000F);
    wr(`ARC_OFF_GAIN, 32'h0000_00C8);
    ticks(1);
    out_chk(32'h0000_0007);
    wr(`ARC_OFF_GAIN, 32'h0000_0000);
    ticks(1);
    out_chk(32'h0000_7FFF);
    wr(`ARC_OFF_GAIN, 32'h0000_0064);
    wr(`ARC_OFF_CEIL, 32'h0000_001E);
    drive(1'b1, 1'b0, 1'b0);
    ticks(6);
    rd_chk("ceiling level", `ARC_OFF_LEVEL, 32'h0000_001E);
    req_first <= 16'sh0019;
    wr(`ARC_OFF_CTRL, 32'h0000_0001);
    ticks(6);
    rd_chk("outside level", `ARC_OFF_LEVEL, 32'h0000_0019);
    drive(1'b1, 1'b0, 1'b1);
    ticks(1);
    rd_chk("stop dwell level", `ARC_OFF_LEVEL, 32'h0000_000F);
    ticks(1);
    rd_chk("stop end level", `ARC_OFF_LEVEL, 32'h0000_0005);
    ticks(6);
    rd_chk("halt level", `ARC_OFF_LEVEL, 32'h0000_0005);
    out_chk(32'h0000_0000);
    rd_chk("locked state", `ARC_OFF_STAT, 32'h0000_0021);
    drive(1'b0, 1'b0, 1'b1);
    drive(1'b1, 1'b0, 1'b1);
    ticks(3);
    rd_chk("refused restart", `ARC_OFF_LEVEL, 32'h0000_0005);
    drive(1'b0, 1'b0, 1'b0);
    drive(1'b1, 1'b0, 1'b0);
    rd_chk("restart level", `ARC_OFF_LEVEL, 32'h0000_000F);
    ticks(4);
    drive(1'b0, 1'b0, 1'b0);
    rd_chk("enable fall level", `ARC_OFF_LEVEL, 32'h0000_0005);
    out_chk(32'h0000_0000);
    rd_chk("idle state", `ARC_OFF_STAT, 32'h0000_0001);
    final_report();
  end
endmodule
